/* shared/sysctl_pkg.sv */
// Constants, register map and types for the system reset and exception controller
`default_nettype none
package sysctl_pkg;
	localparam int          CNT_W            = 12;
	localparam int          INT_N            = 8;
	localparam logic [11:0] OFF_RESET_CAUSE  = 12'h000;
	localparam logic [11:0] OFF_CONFIG       = 12'h004;
	localparam logic [11:0] OFF_BREAK_FLAG   = 12'h008;
	localparam logic [11:0] OFF_INT_STATUS   = 12'h00c;
	localparam int          BIT_WD_DISABLE   = 0;
	localparam int          BIT_STOP_ENABLE  = 1;
	localparam int          BIT_LV_PWRDN     = 2;
	localparam int          BIT_LV_RST_DIS   = 3;
	localparam int          BIT_SHORT_REC    = 4;
	localparam int          BIT_BREAK_CLR_EN = 0;
	localparam int          CAUSE_W          = 6;
	localparam int          CAUSE_POR        = 0;
	localparam int          CAUSE_PIN        = 1;
	localparam int          CAUSE_WD         = 2;
	localparam int          CAUSE_ILLEGAL_OPCODE_FLAG       = 3;
	localparam int          CAUSE_ILLEGAL_ADDRESS_FLAG       = 4;
	localparam int          CAUSE_LV         = 5;
	localparam logic [4:0]  CONFIG_RST       = 5'h00;
	localparam logic [5:0]  CAUSE_RST        = 6'h01;
	localparam logic [12:0] PIN_LOW_CYC      = 13'd32;
	localparam logic [12:0] INTERNAL_RESET_EXTRA_CYC   = 13'd32;
	localparam logic [12:0] LONG_CYC         = 13'd4096;
	localparam logic [12:0] RELEASE_CYC      = 13'd64;
	localparam logic [12:0] SHORT_REC_CYC    = 13'd32;
	localparam logic [1:0]  RESP_OKAY        = 2'b00;
	localparam logic [1:0]  RESP_SLVERR      = 2'b10;
	typedef enum logic [2:0] {
		ST_RUN     = 3'b000,
		ST_PINLOW  = 3'b001,
		ST_INTERNAL_RESET    = 3'b011,
		ST_LVHOLD  = 3'b010,
		ST_LVREL   = 3'b110,
		ST_STOP    = 3'b111,
		ST_STOPREC = 3'b101
	} rst_state_t;
endpackage : sysctl_pkg
`default_nettype wire

/* sim/cpu_model.sv */
// CPU core stand-in: instruction boundaries, program counter, service completion
`default_nettype none
module cpu_model (
	input  wire logic  core_clk_i,
	input  wire logic  rst_n_i,
	input  wire logic  int_take_i,
	output logic       instr_end_o,
	output logic [15:0] pc_o,
	output logic       int_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase_reg;
	logic [2:0] svc_reg;
	assign instr_end_o = (phase_reg == 2'h3);
	// Service routine finishes three cycles after entry
	assign int_done_o = svc_reg[2];
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_reg <= 2'h0;
			pc_o <= 16'h8000;
			svc_reg <= 3'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			pc_o <= pc_o + {15'h0, instr_end_o};
			svc_reg <= {svc_reg[1:0], int_take_i};
		end
	end
endmodule : cpu_model
`default_nettype wire

/* sim/sysctl_sva.sv */
// Port checker for reset sequencing, interrupt entry and break handling
`default_nettype none
module sysctl_sva #(
	parameter int INT_NUM = 8
) (
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	input wire logic        illegal_opcode_i,
	input wire logic        wait_exec_i,
	input wire logic        swi_exec_i,
	input wire logic        break_i,
	input wire logic [15:0] pc_i,
	input wire logic        reset_pin_oe_o,
	input wire logic        internal_reset_o,
	input wire logic        cpu_clk_en_o,
	input wire logic        int_take_o,
	input wire logic [15:0] stack_pc_o,
	input wire logic        stack_index_high_o,
	input wire logic        mask_o,
	input wire logic        break_state_o,
	input wire logic        flag_clear_allow_o,
	input wire logic [$clog2(INT_NUM+1)-1:0] int_vector_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_pin_low;
		reset_pin_oe_o && internal_reset_o ##31 reset_pin_oe_o;
	endsequence
	sequence s_internal_reset_tail;
		!reset_pin_oe_o && internal_reset_o ##31 internal_reset_o ##1 !internal_reset_o && cpu_clk_en_o;
	endsequence
	property p_int_rst;
		cpu_clk_en_o && illegal_opcode_i |=> s_pin_low ##1 s_internal_reset_tail;
	endproperty
	property p_no_index;
		stack_index_high_o == 1'b0;
	endproperty
	property p_hw_stack;
		int_take_o && !swi_exec_i && !break_i |=> mask_o && int_vector_o != 0 && stack_pc_o == $past(pc_i) - 16'h1;
	endproperty
	property p_swi;
		swi_exec_i && cpu_clk_en_o |-> int_take_o ##1 (int_vector_o == 0 && stack_pc_o == $past(pc_i));
	endproperty
	property p_masked;
		mask_o && !swi_exec_i && !break_i |-> !int_take_o;
	endproperty
	property p_wait;
		wait_exec_i && cpu_clk_en_o && !int_take_o |=> !mask_o;
	endproperty
	property p_break;
		break_i && cpu_clk_en_o |=> break_state_o;
	endproperty
	property p_flag;
		!break_state_o |-> flag_clear_allow_o;
	endproperty
	a_int_rst: assert property (p_int_rst) else $error("internal reset timing wrong");
	a_no_index: assert property (p_no_index) else $error("index high stacked");
	a_hw_stack: assert property (p_hw_stack) else $error("hardware entry wrong");
	a_swi: assert property (p_swi) else $error("software entry wrong");
	a_masked: assert property (p_masked) else $error("masked interrupt taken");
	a_wait: assert property (p_wait) else $error("wait left mask set");
	a_break: assert property (p_break) else $error("break state missing");
	a_flag: assert property (p_flag) else $error("flag clear blocked");
endmodule : sysctl_sva
bind sysctl sysctl_sva #(.INT_NUM(INT_NUM)) u_sva (.*);
`default_nettype wire

/* sim/tb.sv */
// Directed bench for the reset and exception controller
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sysctl_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        power_on_pulse_i = 1'b0;
	logic        low_voltage_i = 1'b0;
	logic        rti_exec_i = 1'b0;
	logic        two_step_first_i = 1'b0;
	logic        pin_pull_low = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [7:0]  ev = 8'h00, int_req_i = 8'h00, int_en_i = 8'h00;
	logic [15:0] pc_seen;
	int          fail_count = 0, compares = 0, n;
	wire logic   reset_pin_out_o, reset_pin_oe_o, internal_reset_o, cpu_clk_en_o, watchdog_tick_o, int_take_o;
	wire logic   stack_index_high_o, mask_o, break_state_o, flag_clear_allow_o, two_step_armed_o;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_end_i, int_done_i;
	wire logic [3:0]  int_vector_o;
	wire logic [15:0] stack_pc_o, pc_i;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic   watchdog_overflow_i = ev[0], illegal_opcode_i = ev[1], stop_exec_i = ev[2], wait_exec_i = ev[3];
	wire logic   swi_exec_i = ev[4], break_i = ev[5], unmapped_addr_i = ev[6], opcode_fetch_i = ev[7];
	// Reset pin has a pull-up; the device only pulls it low
	wire logic   reset_pin_in_i = reset_pin_oe_o ? reset_pin_out_o : !pin_pull_low;
	sysctl #(.INT_NUM(8)) uut (.*);
	cpu_model u_cpu (.core_clk_i, .rst_n_i, .int_take_i(int_take_o), .instr_end_o(instr_end_i), .pc_o(pc_i),
		.int_done_o(int_done_i));
	always #5 core_clk_i = ~core_clk_i;
	task note(input string m);
		fail_count++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : note
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) note(m);
	endtask : chk
	task give_verdict;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	task step(input logic [7:0] m);
		ev <= m;
		@(posedge core_clk_i);
		ev <= 8'h00;
	endtask : step
	task wr(input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk_i);
			k++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 50);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY}, "bresp");
		if (k >= 50) note("write timeout");
		@(posedge core_clk_i);
	endtask : wr
	task rdc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] resp);
		int k;
		k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk_i);
			k++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 50);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, exp, "rdata");
		chk({30'h0, s_axi_rresp}, {30'h0, resp}, "rresp");
		if (k >= 50) note("read timeout");
		@(posedge core_clk_i);
	endtask : rdc
	// Fire a cause, time the pin and internal reset phases, then read the cause flags
	task trip(input logic [7:0] m, input logic [5:0] cause, input int len);
		int po, pi, k;
		po = 0;
		pi = 0;
		k = 0;
		step(m);
		do begin
			@(posedge core_clk_i);
			po += int'(reset_pin_oe_o === 1'b1);
			pi += int'(internal_reset_o === 1'b1);
			k++;
		end while (cpu_clk_en_o !== 1'b1 && k < 200);
		if (k >= 200) note("release timeout");
		chk(po, len, "pin low time");
		chk(pi, 2 * len, "internal reset time");
		rdc(OFF_RESET_CAUSE, {26'h0, cause}, RESP_OKAY);
	endtask : trip
	initial begin
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		for (n = 0; n < 5000 && cpu_clk_en_o !== 1'b1; n++) @(posedge core_clk_i);
		if (n >= 5000) note("no release");
		rdc(OFF_RESET_CAUSE, {26'h0, CAUSE_RST}, RESP_OKAY);
		rdc(OFF_RESET_CAUSE, 32'h0, RESP_OKAY);
		rdc(OFF_CONFIG, 32'h0, RESP_OKAY);
		rdc(12'h010, 32'h0, RESP_SLVERR);
		trip(8'h01, 6'h04, 32);
		wr(OFF_CONFIG, 32'h1);
		trip(8'h01, 6'h00, 0);
		wr(OFF_CONFIG, 32'h0);
		trip(8'h02, 6'h08, 32);
		trip(8'h04, 6'h08, 32);
		trip(8'h40, 6'h00, 0);
		trip(8'hc0, 6'h10, 32);
		for (n = 0; n < 5000 && watchdog_tick_o !== 1'b1; n++) @(posedge core_clk_i);
		@(posedge core_clk_i);
		for (n = 1; n < 5000 && watchdog_tick_o !== 1'b1; n++) @(posedge core_clk_i);
		chk(n, 4096, "tick period");
		pin_pull_low <= 1'b1;
		repeat (40) @(posedge core_clk_i);
		pin_pull_low <= 1'b0;
		for (n = 40; n < 5000 && watchdog_tick_o !== 1'b1; n++) @(posedge core_clk_i);
		chk(n, 4096, "pin keeps counter");
		rdc(OFF_RESET_CAUSE, 32'h2, RESP_OKAY);
		wr(OFF_CONFIG, 32'h8);
		low_voltage_i <= 1'b1;
		@(posedge core_clk_i);
		low_voltage_i <= 1'b0;
		@(posedge core_clk_i);
		chk(internal_reset_o, 1'b0, "lv reset disabled");
		wr(OFF_CONFIG, 32'h0);
		low_voltage_i <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		low_voltage_i <= 1'b0;
		@(posedge core_clk_i);
		for (n = 0; n < 5000 && reset_pin_oe_o === 1'b1; n++) @(posedge core_clk_i);
		chk(n, 4096, "lv pin hold");
		for (n = 0; n < 200 && cpu_clk_en_o !== 1'b1; n++) @(posedge core_clk_i);
		chk(n, 64, "lv release");
		rdc(OFF_RESET_CAUSE, 32'h20, RESP_OKAY);
		wr(OFF_CONFIG, 32'h12);
		step(8'h04);
		@(negedge core_clk_i);
		chk(cpu_clk_en_o, 1'b0, "stop clock");
		chk(mask_o, 1'b0, "stop mask");
		@(posedge core_clk_i);
		int_en_i <= 8'h01;
		int_req_i <= 8'h01;
		repeat (2) @(posedge core_clk_i);
		for (n = 0; n < 5000 && cpu_clk_en_o !== 1'b1; n++) @(posedge core_clk_i);
		chk(n, 32, "stop recovery");
		int_req_i <= 8'h00;
		int_en_i <= 8'h00;
		wr(OFF_CONFIG, 32'h0);
		step(8'h10);
		pc_seen = pc_i;
		chk(int_take_o, 1'b1, "swi take");
		@(negedge core_clk_i);
		chk(int_vector_o, 4'h0, "swi vector");
		chk(stack_pc_o, pc_seen, "swi stack");
		repeat (8) @(posedge core_clk_i);
		int_en_i <= 8'hff;
		int_req_i <= 8'h28;
		n = 0;
		repeat (20) begin
			@(posedge core_clk_i);
			if (int_take_o === 1'b1) n++;
		end
		chk(n, 0, "masked take");
		step(8'h08);
		@(negedge core_clk_i);
		chk(mask_o, 1'b0, "wait mask");
		chk(cpu_clk_en_o, 1'b0, "wait clock");
		for (n = 0; n < 50 && int_take_o !== 1'b1; n++) @(posedge core_clk_i);
		pc_seen = pc_i;
		@(negedge core_clk_i);
		chk(n < 50, 1'b1, "no take");
		chk(int_vector_o, 4'h4, "priority");
		chk(stack_pc_o, pc_seen - 16'h1, "hw stack");
		chk(mask_o, 1'b1, "mask set");
		chk(stack_index_high_o, 1'b0, "index");
		repeat (8) @(posedge core_clk_i);
		int_req_i <= 8'h00;
		two_step_first_i <= 1'b1;
		ev <= 8'h20;
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(break_state_o, 1'b1, "break state");
		chk(int_vector_o, 4'h0, "break vector");
		chk(flag_clear_allow_o, 1'b0, "flags guarded");
		chk(two_step_armed_o, 1'b0, "two step held in break");
		@(posedge core_clk_i);
		wr(OFF_BREAK_FLAG, 32'h1);
		chk(flag_clear_allow_o, 1'b1, "flags clearable");
		chk(two_step_armed_o, 1'b1, "two step clearable");
		give_verdict();
	end
endmodule : tb
`default_nettype wire

/* src/sysctl.sv */
// System reset, counter and exception control with an AXI4-Lite register slave
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none
// Behaviour
// - Watchdog overflow with watchdog enabled resets chip and sets watchdog flag.
// - Illegal instruction from CPU sets illegal-opcode flag and resets.
// - Stop instruction while stop disabled counts as illegal opcode.
// - Only opcode fetches from unmapped addresses set illegal-address flag and reset.
// - Low voltage with power-down and reset-disable both clear sets flag, resets.
// - Low-voltage reset holds pin 4096 cycles after recovery, CPU freed 64 later.
// - System counter is 12 bits and advances every cycle unless an internal reset or stop clears it.
// - Counter overflow is the watchdog clock tick.
// - Stop clears counter; wake uses 32 cycles if short-recovery set, else 4096.
// - External pin reset does not clear the system counter; it keeps counting.
// - Counter runs freely after every reset state.
// - Interrupt entry stacks PC and sets mask; return clears mask and latch.
// - Latched interrupt is never preempted by a hardware interrupt until serviced or mask clears.
// - At instruction end take interrupt only if unmasked and source enabled.
// - Highest-priority pending interrupt is serviced first.
// - High index register is not stacked on interrupt entry.
// - Software interrupt is taken regardless of the mask.
// - Software interrupt stacks PC, hardware interrupt stacks PC minus one.
// - Any reset beats every interrupt without arbitration.
// - Break forces a fetch from the software interrupt vector.
// - In break, flags clear only with break-clear-enable; cleared stays cleared.
// - With break-clear-enable clear, two-step clears started before break finish only after break.
// - Wait or stop clears mask and stops CPU clock.
// - Internal reset drives pin low 32 cycles, then internal reset 32 more.
// - Reading reset cause register clears all cause flags.
module sysctl #(
	parameter int INT_NUM = sysctl_pkg::INT_N
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     power_on_pulse_i,
	input  wire logic                     reset_pin_in_i,
	output logic                          reset_pin_out_o,
	output logic                          reset_pin_oe_o,
	output logic                          internal_reset_o,
	output logic                          cpu_clk_en_o,
	output logic                          watchdog_tick_o,
	input  wire logic                     watchdog_overflow_i,
	input  wire logic                     illegal_opcode_i,
	input  wire logic                     stop_exec_i,
	input  wire logic                     wait_exec_i,
	input  wire logic                     opcode_fetch_i,
	input  wire logic                     unmapped_addr_i,
	input  wire logic                     low_voltage_i,
	input  wire logic                     instr_end_i,
	input  wire logic                     swi_exec_i,
	input  wire logic                     rti_exec_i,
	input  wire logic                     int_done_i,
	input  wire logic [INT_NUM-1:0]       int_req_i,
	input  wire logic [INT_NUM-1:0]       int_en_i,
	input  wire logic [15:0]              pc_i,
	output logic                          int_take_o,
	output logic [$clog2(INT_NUM+1)-1:0]  int_vector_o,
	output logic [15:0]                   stack_pc_o,
	output logic                          stack_index_high_o,
	output logic                          mask_o,
	input  wire logic                     break_i,
	output logic                          break_state_o,
	output logic                          flag_clear_allow_o,
	input  wire logic                     two_step_first_i,
	output logic                          two_step_armed_o,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [11:0]              s_axi_awaddr,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	output logic [1:0]                    s_axi_bresp,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	input  wire logic [11:0]              s_axi_araddr,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp
);
	import sysctl_pkg::*;

	localparam int VW = $clog2(INT_NUM + 1);
	if (INT_NUM < 1 || INT_NUM > 30) begin : g_chk
		$error("INT_NUM out of range");
	end

	// Lowest index wins; vector 0 is reserved for the software interrupt
	function automatic logic [VW-1:0] prio_enc(input logic [INT_NUM-1:0] req);
		logic [VW-1:0] v;
		v = '0;
		for (int i = INT_NUM - 1; i >= 0; i--) begin
			if (req[i]) begin
				v = VW'(i + 1);
			end
		end
		return v;
	endfunction : prio_enc

	rst_state_t         state_reg;
	rst_state_t         state_next;
	logic [CNT_W-1:0]   cnt_reg;
	logic [CNT_W-1:0]   cnt_next;
	logic [12:0]        tmr_reg;
	logic [12:0]        tmr_next;
	logic [CAUSE_W-1:0] cause_reg;
	logic [4:0]         config_reg;
	logic               break_clear_enable_reg;
	logic               mask_reg;
	logic               latched_reg;
	logic [VW-1:0]      vec_reg;
	logic               armed_reg;
	logic               in_break_reg;
	logic               wait_reg;
	logic               pin_low_reg;
	logic               short_rec_reg;

	logic               aw_got_reg;
	logic               w_got_reg;
	logic [11:0]        awaddr_reg;
	logic [31:0]        wdata_reg;
	logic               bvalid_reg;
	logic [1:0]         bresp_reg;
	logic               rvalid_reg;
	logic [31:0]        rdata_reg;
	logic [1:0]         rresp_reg;

	// Reset event decode; the first matching source is recorded alone
	wire wd_rst   = watchdog_overflow_i && !config_reg[BIT_WD_DISABLE];
	wire stop_ill = stop_exec_i && !config_reg[BIT_STOP_ENABLE];
	wire illegal_opcode_flag_rst = illegal_opcode_i || stop_ill;
	wire illegal_address_flag_rst = opcode_fetch_i && unmapped_addr_i;
	wire lv_rst   = low_voltage_i && !config_reg[BIT_LV_PWRDN] && !config_reg[BIT_LV_RST_DIS];
	wire pin_rst  = !reset_pin_in_i && !pin_low_reg;
	wire int_src  = wd_rst || illegal_opcode_flag_rst || illegal_address_flag_rst || lv_rst || power_on_pulse_i;
	wire any_rst  = int_src || pin_rst;
	wire running  = (state_reg == ST_RUN);
	wire stop_ok  = running && stop_exec_i && config_reg[BIT_STOP_ENABLE] && !any_rst;
	wire tmr_done = (tmr_reg == 13'd1);
	wire wake     = (|(int_req_i & int_en_i)) || break_i;

	logic [CAUSE_W-1:0] cause_set;
	always_comb begin
		cause_set = '0;
		if (power_on_pulse_i) begin
			cause_set[CAUSE_POR] = 1'b1;
		end else if (lv_rst) begin
			cause_set[CAUSE_LV] = 1'b1;
		end else if (wd_rst) begin
			cause_set[CAUSE_WD] = 1'b1;
		end else if (illegal_address_flag_rst) begin
			cause_set[CAUSE_ILLEGAL_ADDRESS_FLAG] = 1'b1;
		end else if (illegal_opcode_flag_rst) begin
			cause_set[CAUSE_ILLEGAL_OPCODE_FLAG] = 1'b1;
		end else if (pin_rst) begin
			cause_set[CAUSE_PIN] = 1'b1;
		end
	end

	// Reset sequencer
	always_comb begin
		state_next = state_reg;
		tmr_next   = (tmr_reg != 13'd0) ? tmr_reg - 13'd1 : tmr_reg;
		if (power_on_pulse_i || lv_rst) begin
			state_next = ST_LVHOLD;
			tmr_next   = LONG_CYC;
		end else if (int_src) begin
			state_next = ST_PINLOW;
			tmr_next   = PIN_LOW_CYC;
		end else if (pin_rst) begin
			state_next = ST_INTERNAL_RESET;
			tmr_next   = INTERNAL_RESET_EXTRA_CYC;
		end else begin
			unique case (state_reg)
				ST_RUN: begin
					if (stop_ok) begin
						state_next = ST_STOP;
					end
				end
				ST_STOP: begin
					if (wake) begin
						state_next = ST_STOPREC;
						tmr_next   = short_rec_reg ? SHORT_REC_CYC : LONG_CYC;
					end
				end
				ST_STOPREC: begin
					if (tmr_done) begin
						state_next = ST_RUN;
					end
				end
				ST_LVHOLD: begin
					if (tmr_done && !low_voltage_i) begin
						state_next = ST_LVREL;
						tmr_next   = RELEASE_CYC;
					end else if (low_voltage_i) begin
						tmr_next = LONG_CYC;
					end
				end
				ST_LVREL: begin
					if (tmr_done) begin
						state_next = ST_RUN;
					end
				end
				ST_PINLOW: begin
					if (tmr_done) begin
						state_next = ST_INTERNAL_RESET;
						tmr_next   = INTERNAL_RESET_EXTRA_CYC;
					end
				end
				ST_INTERNAL_RESET: begin
					if (tmr_done && reset_pin_in_i) begin
						state_next = ST_RUN;
					end
				end
				default: state_next = ST_RUN;
			endcase
		end
	end

	// Counter: cleared by internal resets and stop, untouched by the pin
	always_comb begin
		cnt_next = cnt_reg + 12'd1;
		if (int_src || stop_ok || state_reg == ST_STOP) begin
			cnt_next = '0;
		end else if (pin_rst) begin
			cnt_next = cnt_reg + 12'd1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg     <= ST_LVHOLD;
			tmr_reg       <= LONG_CYC;
			cnt_reg       <= '0;
			pin_low_reg   <= 1'b1;
			short_rec_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			tmr_reg       <= tmr_next;
			cnt_reg       <= cnt_next;
			pin_low_reg   <= (state_next == ST_PINLOW) || (state_next == ST_LVHOLD);
			short_rec_reg <= config_reg[BIT_SHORT_REC];
		end
	end

	assign watchdog_tick_o  = (cnt_reg == '1);
	assign reset_pin_out_o  = 1'b0;
	assign reset_pin_oe_o   = pin_low_reg;
	assign internal_reset_o = !running && state_reg != ST_STOP && state_reg != ST_STOPREC;
	// Wait parks the CPU clock until a wake source or reset arrives
	assign cpu_clk_en_o     = running && !in_break_reg && !wait_reg;

	// Interrupt latch and arbitration
	wire [INT_NUM-1:0] pend = int_req_i & int_en_i;
	wire hw_take = instr_end_i && !mask_reg && (|pend) && !latched_reg && running;
	wire sw_take = (swi_exec_i || (break_i && !in_break_reg)) && running;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_reg     <= 1'b1;
			latched_reg  <= 1'b0;
			vec_reg      <= '0;
			stack_pc_o   <= '0;
			in_break_reg <= 1'b0;
			armed_reg    <= 1'b0;
			wait_reg     <= 1'b0;
		end else begin
			if (any_rst) begin
				wait_reg <= 1'b0;
			end else if (wait_exec_i && running) begin
				wait_reg <= 1'b1;
			end else if (wake) begin
				wait_reg <= 1'b0;
			end
			if (any_rst) begin
				latched_reg <= 1'b0;
				mask_reg    <= 1'b1;
			end else if (sw_take) begin
				latched_reg <= 1'b1;
				vec_reg     <= '0;
				mask_reg    <= 1'b1;
				stack_pc_o  <= pc_i;
			end else if (hw_take) begin
				latched_reg <= 1'b1;
				vec_reg     <= prio_enc(pend);
				mask_reg    <= 1'b1;
				stack_pc_o  <= pc_i - 16'd1;
			end else begin
				if (int_done_i) begin
					latched_reg <= 1'b0;
				end
				if (rti_exec_i || stop_exec_i || wait_exec_i) begin
					mask_reg    <= 1'b0;
					latched_reg <= 1'b0;
				end
			end
			if (any_rst || rti_exec_i) begin
				in_break_reg <= 1'b0;
			end else if (break_i) begin
				in_break_reg <= 1'b1;
			end
			if (two_step_first_i && !in_break_reg) begin
				armed_reg <= 1'b1;
			end else if (two_step_first_i && in_break_reg && break_clear_enable_reg) begin
				armed_reg <= 1'b1;
			end else if (any_rst) begin
				armed_reg <= 1'b0;
			end
		end
	end

	assign int_take_o         = (sw_take || hw_take) && !any_rst;
	assign int_vector_o       = vec_reg;
	assign stack_index_high_o = 1'b0;
	assign mask_o             = mask_reg;
	assign break_state_o      = in_break_reg;
	assign flag_clear_allow_o = !in_break_reg || break_clear_enable_reg;
	assign two_step_armed_o   = armed_reg && (!in_break_reg || break_clear_enable_reg);

	// AXI4-Lite write path
	wire wr_fire   = (aw_got_reg || s_axi_awvalid) && (w_got_reg || s_axi_wvalid) && !bvalid_reg;
	wire [11:0] wa = aw_got_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0] wd = w_got_reg ? wdata_reg : s_axi_wdata;
	wire wa_cfg    = (wa == OFF_CONFIG);
	wire wa_brk    = (wa == OFF_BREAK_FLAG);
	wire wa_ok     = wa_cfg || wa_brk || (wa == OFF_RESET_CAUSE) || (wa == OFF_INT_STATUS);
	wire ra_ok     = (s_axi_araddr == OFF_RESET_CAUSE) || (s_axi_araddr == OFF_CONFIG)
	               || (s_axi_araddr == OFF_BREAK_FLAG) || (s_axi_araddr == OFF_INT_STATUS);
	wire rd_fire   = s_axi_arvalid && !rvalid_reg;
	wire cause_rd  = rd_fire && (s_axi_araddr == OFF_RESET_CAUSE) && (!in_break_reg || break_clear_enable_reg);

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready  = !w_got_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg  <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
			config_reg <= CONFIG_RST;
			break_clear_enable_reg   <= 1'b0;
		end else begin
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg  <= wa_ok ? RESP_OKAY : RESP_SLVERR;
				if (wa_cfg && s_axi_wstrb[0]) begin
					config_reg <= wd[4:0];
				end
				if (wa_brk && s_axi_wstrb[0]) begin
					break_clear_enable_reg <= wd[BIT_BREAK_CLR_EN];
				end
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_got_reg <= 1'b1;
					awaddr_reg <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_got_reg <= 1'b1;
					wdata_reg <= s_axi_wdata;
				end
				if (bvalid_reg && s_axi_bready) begin
					bvalid_reg <= 1'b0;
				end
			end
		end
	end

	// AXI4-Lite read path; a new reset cause wins over a read clear
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		unique case (s_axi_araddr)
			OFF_RESET_CAUSE: rd_mux = {26'h0, cause_reg};
			OFF_CONFIG:      rd_mux = {27'h0, config_reg};
			OFF_BREAK_FLAG:  rd_mux = {31'h0, break_clear_enable_reg};
			OFF_INT_STATUS:  rd_mux = {24'h0, in_break_reg, latched_reg, mask_reg, 5'(vec_reg)};
			default:         rd_mux = '0;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
			cause_reg  <= CAUSE_RST;
		end else begin
			if (rd_fire) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_mux;
				rresp_reg  <= ra_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
			if (|cause_set) begin
				cause_reg <= cause_set;
			end else if (cause_rd) begin
				cause_reg <= '0;
			end
		end
	end
endmodule : sysctl
`default_nettype wire
